// ---- core/nbp_pkg.sv ----
package nbp_pkg;
	localparam int          CLK_NS      = 10;
	localparam int          T_WP_NS     = 12;
	localparam int          T_WH_NS     = 10;
	localparam int          T_WW_NS     = 100;
	localparam int          T_RLO_NS    = 20;
	localparam int          T_RHI_NS    = 10;
	localparam int          T_WB_NS     = 100;
	localparam int          WE_LO_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int          WE_HI_CYC   = (T_WH_NS + CLK_NS - 1) / CLK_NS;
	localparam int          RE_LO_CYC   = (T_RLO_NS + CLK_NS - 1) / CLK_NS;
	localparam int          RE_HI_CYC   = (T_RHI_NS + CLK_NS - 1) / CLK_NS;
	localparam int          WW_CYC      = (T_WW_NS + CLK_NS - 1) / CLK_NS;
	localparam int          WB_CYC      = (T_WB_NS + CLK_NS - 1) / CLK_NS;
	localparam int          BLK_W       = 12;
	localparam logic [7:0]  OFS_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_LOW     = 8'h04;
	localparam logic [7:0]  OFS_UP      = 8'h08;
	localparam logic [7:0]  OFS_CFG     = 8'h0C;
	localparam logic [7:0]  OFS_STAT    = 8'h10;
	localparam logic [7:0]  OFS_IRQ_ST  = 8'h14;
	localparam logic [7:0]  OFS_IRQ_CLR = 8'h18;
	localparam logic [7:0]  OFS_IRQ_EN  = 8'h1C;
	localparam int          F_INV       = 16;
	localparam int          F_WP        = 0;
	localparam int          F_BUSY      = 0;
	localparam int          F_RD_LSB    = 8;
	localparam int          F_UNLOCKED  = 16;
	localparam int          F_SOLID     = 17;
	localparam int          IRQ_W       = 2;
	localparam int          IRQ_DONE    = 0;
	localparam int          IRQ_SOLID   = 1;
	localparam int          ST_SOLID    = 0;
	localparam int          ST_SOLID_N  = 1;
	localparam int          ST_UNLOCKED = 2;
	localparam logic [7:0]  CMD_UNP_LO  = 8'h23;
	localparam logic [7:0]  CMD_UNP_UP  = 8'h24;
	localparam logic [7:0]  CMD_PROT    = 8'h2A;
	localparam logic [7:0]  CMD_SOLID   = 8'h2C;
	localparam logic [7:0]  CMD_BSTAT   = 8'h7A;
	localparam logic [7:0]  CMD_STAT    = 8'h70;
	typedef enum logic [2:0] {
		OP_NONE   = 3'b000,
		OP_UNPROT = 3'b001,
		OP_PROT   = 3'b010,
		OP_SOLID  = 3'b011,
		OP_BSTAT  = 3'b100,
		OP_STAT   = 3'b101
	} nbp_op_e;
	typedef enum logic [1:0] {
		K_CMD  = 2'b00,
		K_ADDR = 2'b01,
		K_READ = 2'b10
	} nbp_kind_e;
endpackage : nbp_pkg

// ---- core/nbp_cycle.sv ----
`timescale 1ns/1ns
module nbp_cycle
	import nbp_pkg::*;
#(
	parameter int IO_W = 8
) (
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            en_i,
	input  wire logic            start_i,
	input  wire nbp_kind_e       kind_i,
	input  wire logic [7:0]      byte_i,
	input  wire logic [IO_W-1:0] io_i,
	output logic                 cle_o,
	output logic                 ale_o,
	output logic                 we_n_o,
	output logic                 re_n_o,
	output logic                 io_oe_o,
	output logic [IO_W-1:0]      io_o,
	output logic [7:0]           rdata_o,
	output logic                 done_o
);
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_SET  = 2'b01,
		PH_LO   = 2'b10,
		PH_HI   = 2'b11
	} nbp_ph_e;

	nbp_ph_e    ph_reg;
	logic [3:0] cnt_reg;
	logic       rd_reg;

	// Data and latches held through WE high so the device sees hold time
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ph_reg  <= PH_IDLE;
			cnt_reg <= 4'h0;
			rd_reg  <= 1'b0;
			cle_o   <= 1'b0;
			ale_o   <= 1'b0;
			we_n_o  <= 1'b1;
			re_n_o  <= 1'b1;
			io_oe_o <= 1'b0;
			io_o    <= '0;
			rdata_o <= 8'h00;
			done_o  <= 1'b0;
		end else if (en_i) begin
			done_o <= 1'b0;
			unique case (ph_reg)
				PH_IDLE: if (start_i) begin
					rd_reg <= (kind_i == K_READ);
					if (kind_i == K_READ) begin
						re_n_o  <= 1'b0;
						cnt_reg <= 4'(RE_LO_CYC - 1);
						ph_reg  <= PH_LO;
					end else begin
						cle_o   <= (kind_i == K_CMD);
						ale_o   <= (kind_i == K_ADDR);
						io_o    <= IO_W'(byte_i);
						io_oe_o <= 1'b1;
						ph_reg  <= PH_SET;
					end
				end
				PH_SET: begin
					we_n_o  <= 1'b0;
					cnt_reg <= 4'(WE_LO_CYC - 1);
					ph_reg  <= PH_LO;
				end
				PH_LO: if (cnt_reg == 4'h0) begin
					if (rd_reg) begin
						rdata_o <= io_i[7:0];
						re_n_o  <= 1'b1;
						cnt_reg <= 4'(RE_HI_CYC - 1);
					end else begin
						we_n_o  <= 1'b1;
						cnt_reg <= 4'(WE_HI_CYC - 1);
					end
					ph_reg <= PH_HI;
				end else begin
					cnt_reg <= cnt_reg - 4'h1;
				end
				PH_HI: if (cnt_reg == 4'h0) begin
					done_o  <= 1'b1;
					cle_o   <= 1'b0;
					ale_o   <= 1'b0;
					io_oe_o <= 1'b0;
					ph_reg  <= PH_IDLE;
				end else begin
					cnt_reg <= cnt_reg - 4'h1;
				end
			endcase
		end
	end
endmodule : nbp_cycle

// ---- core/nbp_ctrl.sv ----
`timescale 1ns/1ns
module nbp_ctrl
	import nbp_pkg::*;
#(
	parameter int IO_W = 8
) (
	input  wire logic            MCLK_I,
	input  wire logic            RESET_I,
	input  wire logic            EN_I,
	input  wire logic            PSEL_I,
	input  wire logic            PENABLE_I,
	input  wire logic            PWRITE_I,
	input  wire logic [7:0]      PADDR_I,
	input  wire logic [31:0]     PWDATA_I,
	output logic [31:0]          PRDATA_O,
	output logic                 PREADY_O,
	output logic                 PSLVERR_O,
	output logic                 IRQ_O,
	output logic                 CE_N_O,
	output logic                 CLE_O,
	output logic                 ALE_O,
	output logic                 WE_N_O,
	output logic                 RE_N_O,
	output logic                 WP_N_O,
	input  wire logic [IO_W-1:0] IO_I,
	output logic [IO_W-1:0]      IO_O,
	output logic                 IO_OE_O,
	input  wire logic            RB_I
);
	generate
		if (IO_W != 8 && IO_W != 16) begin : g_bad_width
			$error("IO_W must be 8 or 16");
		end
	endgenerate

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_WP   = 3'b001,
		S_CYC  = 3'b010,
		S_WAIT = 3'b011,
		S_GAP  = 3'b100,
		S_RB   = 3'b101
	} nbp_state_e;

	nbp_state_e       state_reg;
	nbp_op_e          op_reg;
	logic [2:0]       idx_reg;
	logic [4:0]       cnt_reg;
	logic [4:0]       wp_cnt_reg;
	logic [BLK_W-1:0] low_reg;
	logic [BLK_W-1:0] up_reg;
	logic             inv_reg;
	logic [IRQ_W-1:0] irq_st_reg;
	logic [IRQ_W-1:0] irq_en_reg;
	logic [7:0]       rd_byte;
	logic [7:0]       last_cmd_reg;
	logic [1:0]       addr_cnt_reg;
	logic [10:0]      cur;
	nbp_kind_e        cyc_kind;
	logic [7:0]       cyc_byte;
	logic             cyc_start;
	logic             cyc_done;
	logic             op_done;
	logic             wr_acc;
	logic             go;
	logic [IRQ_W-1:0] ev;

	// {last, kind, command} of step i of an operation
	function automatic logic [10:0] step(input nbp_op_e op, input logic [2:0] i);
		unique case (op)
			OP_UNPROT: step = (i == 3'd0) ? {1'b0, K_CMD, CMD_UNP_LO} :
				(i == 3'd4) ? {1'b0, K_CMD, CMD_UNP_UP} :
				{i == 3'd7, K_ADDR, 8'h00};
			OP_PROT:   step = {1'b1, K_CMD, CMD_PROT};
			OP_SOLID:  step = {1'b1, K_CMD, CMD_SOLID};
			OP_BSTAT:  step = (i == 3'd0) ? {1'b0, K_CMD, CMD_BSTAT} :
				(i == 3'd4) ? {1'b1, K_READ, 8'h00} : {1'b0, K_ADDR, 8'h00};
			OP_STAT:   step = (i == 3'd0) ? {1'b0, K_CMD, CMD_STAT} :
				{1'b1, K_READ, 8'h00};
			default:   step = {1'b1, K_CMD, CMD_STAT};
		endcase
	endfunction : step

	// Same bit layout on both widths; wide lanes stay low
	function automatic logic [7:0] addr_byte(input logic [BLK_W-1:0] b, input logic inv,
		input logic [1:0] n);
		unique case (n)
			2'd0:    addr_byte = {b[1:0], 5'b00000, inv};
			2'd1:    addr_byte = b[9:2];
			default: addr_byte = {6'b000000, b[11:10]};
		endcase
	endfunction : addr_byte

	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a == OFS_CTRL) || (a == OFS_LOW) || (a == OFS_UP) || (a == OFS_CFG) ||
			(a == OFS_STAT) || (a == OFS_IRQ_ST) || (a == OFS_IRQ_CLR) || (a == OFS_IRQ_EN);
	endfunction : reg_hit

	assign cur       = step(op_reg, idx_reg);
	assign cyc_kind  = nbp_kind_e'(cur[9:8]);
	// Lower boundary goes out with invert zero; the device ignores it there
	assign cyc_byte  = (cyc_kind != K_ADDR) ? cur[7:0] :
		(idx_reg < 3'd4) ? addr_byte(low_reg, 1'b0, 2'(idx_reg[1:0] - 2'd1)) :
		addr_byte(up_reg, inv_reg, 2'(idx_reg[1:0] - 2'd1));
	assign cyc_start = EN_I && (state_reg == S_CYC);
	assign op_done   = EN_I && (state_reg == S_RB) && RB_I;
	assign wr_acc    = PSEL_I && PENABLE_I && PWRITE_I;
	assign go        = wr_acc && (PADDR_I == OFS_CTRL) && (state_reg == S_IDLE) &&
		(PWDATA_I[2:0] >= OP_UNPROT) && (PWDATA_I[2:0] <= OP_STAT);
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = PSEL_I && PENABLE_I && !reg_hit(PADDR_I);

	nbp_cycle #(
		.IO_W(IO_W)
	) u_cycle (
		.clk_i  (MCLK_I),
		.rst_i  (RESET_I),
		.en_i   (EN_I),
		.start_i(cyc_start),
		.kind_i (cyc_kind),
		.byte_i (cyc_byte),
		.io_i   (IO_I),
		.cle_o  (CLE_O),
		.ale_o  (ALE_O),
		.we_n_o (WE_N_O),
		.re_n_o (RE_N_O),
		.io_oe_o(IO_OE_O),
		.io_o   (IO_O),
		.rdata_o(rd_byte),
		.done_o (cyc_done)
	);

	// Sequencer; a new order is refused while busy
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			state_reg <= S_IDLE;
			op_reg    <= OP_NONE;
			idx_reg   <= 3'd0;
			cnt_reg   <= 5'd0;
			CE_N_O    <= 1'b1;
		end else if (EN_I) begin
			unique case (state_reg)
				S_IDLE: if (go) begin
					op_reg    <= nbp_op_e'(PWDATA_I[2:0]);
					idx_reg   <= 3'd0;
					CE_N_O    <= 1'b0;
					state_reg <= (PWDATA_I[2:0] == OP_SOLID) ? S_WP : S_CYC;
				end
				S_WP: if (WP_N_O && wp_cnt_reg == 5'(WW_CYC)) begin
					state_reg <= S_CYC;
				end
				S_CYC:  state_reg <= S_WAIT;
				S_WAIT: if (cyc_done) begin
					if (cur[10]) begin
						cnt_reg   <= 5'(WB_CYC);
						state_reg <= S_GAP;
					end else begin
						idx_reg   <= idx_reg + 3'd1;
						state_reg <= S_CYC;
					end
				end
				S_GAP: if (cnt_reg == 5'd0) begin
					state_reg <= S_RB;
				end else begin
					cnt_reg <= cnt_reg - 5'd1;
				end
				// Rejected locked-block work also ends once ready-busy reads high
				S_RB: if (RB_I) begin
					CE_N_O    <= 1'b1;
					state_reg <= S_IDLE;
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// Write-protect pin and its settling count before 2Ch
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			WP_N_O     <= 1'b0;
			wp_cnt_reg <= 5'd0;
		end else if (EN_I) begin
			if (go && PWDATA_I[2:0] == OP_SOLID && !WP_N_O) begin
				WP_N_O     <= 1'b1;
				wp_cnt_reg <= 5'd0;
			end else if (wr_acc && PADDR_I == OFS_CFG && state_reg == S_IDLE &&
				PWDATA_I[F_WP] != WP_N_O) begin
				WP_N_O     <= PWDATA_I[F_WP];
				wp_cnt_reg <= 5'd0;
			end else if (wp_cnt_reg != 5'(WW_CYC)) begin
				wp_cnt_reg <= wp_cnt_reg + 5'd1;
			end
		end
	end

	// Boundaries may be reloaded only while idle
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			low_reg <= '0;
			up_reg  <= '0;
			inv_reg <= 1'b0;
		end else if (EN_I && wr_acc && state_reg == S_IDLE) begin
			if (PADDR_I == OFS_LOW) begin
				low_reg <= PWDATA_I[BLK_W-1:0];
			end
			if (PADDR_I == OFS_UP) begin
				up_reg  <= PWDATA_I[BLK_W-1:0];
				inv_reg <= PWDATA_I[F_INV];
			end
		end
	end

	// Sticky events; a set in the clearing cycle survives
	assign ev[IRQ_DONE]  = op_done;
	assign ev[IRQ_SOLID] = op_done && op_reg == OP_BSTAT && rd_byte[ST_SOLID];
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			irq_st_reg <= '0;
			irq_en_reg <= '0;
		end else if (EN_I) begin
			irq_st_reg <= (irq_st_reg & ~((wr_acc && PADDR_I == OFS_IRQ_CLR) ?
				PWDATA_I[IRQ_W-1:0] : '0)) | ev;
			if (wr_acc && PADDR_I == OFS_IRQ_EN) begin
				irq_en_reg <= PWDATA_I[IRQ_W-1:0];
			end
		end
	end
	assign IRQ_O = |(irq_st_reg & irq_en_reg);

	// Read data captured in the setup cycle, shown in the access cycle
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			PRDATA_O <= 32'h0000_0000;
		end else if (EN_I && PSEL_I && !PENABLE_I && !PWRITE_I) begin
			PRDATA_O <= 32'h0000_0000;
			unique case (PADDR_I)
				OFS_CTRL:   PRDATA_O[2:0] <= op_reg;
				OFS_LOW:    PRDATA_O[BLK_W-1:0] <= low_reg;
				OFS_UP:     PRDATA_O <= {15'h0000, inv_reg, 4'h0, up_reg};
				OFS_CFG:    PRDATA_O[F_WP] <= WP_N_O;
				OFS_STAT:   begin
					PRDATA_O[F_BUSY] <= (state_reg != S_IDLE);
					PRDATA_O[F_RD_LSB+7:F_RD_LSB] <= rd_byte;
					PRDATA_O[F_UNLOCKED] <= rd_byte[ST_UNLOCKED];
					PRDATA_O[F_SOLID] <= rd_byte[ST_SOLID] && !rd_byte[ST_SOLID_N];
				end
				OFS_IRQ_ST: PRDATA_O[IRQ_W-1:0] <= irq_st_reg;
				OFS_IRQ_EN: PRDATA_O[IRQ_W-1:0] <= irq_en_reg;
				default:    PRDATA_O <= 32'h0000_0000;
			endcase
		end
	end

	// Helper history of the pin stream for the checks below
	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			last_cmd_reg <= 8'h00;
			addr_cnt_reg <= 2'd0;
		end else if (cyc_start) begin
			if (cyc_kind == K_CMD) begin
				last_cmd_reg <= cyc_byte;
				addr_cnt_reg <= 2'd0;
			end else if (cyc_kind == K_ADDR && addr_cnt_reg != 2'd3) begin
				addr_cnt_reg <= addr_cnt_reg + 2'd1;
			end
		end
	end

	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (RESET_I);

	sequence s_cmd(logic [7:0] b);
		cyc_start && cyc_kind == K_CMD && cyc_byte == b;
	endsequence
	sequence s_addr(logic [1:0] n);
		cyc_start && cyc_kind == K_ADDR && addr_cnt_reg == n;
	endsequence

	unp_order_a: assert property (s_cmd(CMD_UNP_UP) |->
		last_cmd_reg == CMD_UNP_LO && addr_cnt_reg == 2'd3)
		else $error("upper boundary command not after lower and three addresses");
	addr_first_a: assert property (s_addr(2'd0) |-> cyc_byte[5:1] == 5'd0)
		else $error("first address cycle has reserved bits set");
	addr_third_a: assert property (s_addr(2'd2) |-> cyc_byte[7:2] == 6'd0)
		else $error("third address cycle has reserved bits set");
	upper_lanes_a: assert property (IO_OE_O |-> (IO_O >> 8) == '0)
		else $error("upper data lanes driven high");
	solid_wp_a: assert property (s_cmd(CMD_SOLID) |->
		(WP_N_O && wp_cnt_reg == 5'(WW_CYC)) ##1 WP_N_O [*4])
		else $error("lock command without settled write-protect high");
	bstat_read_a: assert property (cyc_start && cyc_kind == K_READ &&
		last_cmd_reg == CMD_BSTAT |-> addr_cnt_reg == 2'd3)
		else $error("status word read before three address cycles");
endmodule : nbp_ctrl

// ---- sim/nbp_flash_model.sv ----
`timescale 1ns/1ns
module nbp_flash_model
	import nbp_pkg::*;
(
	input  wire logic       por_i,
	input  wire logic       strap_i,
	input  wire logic       ce_n_i,
	input  wire logic       cle_i,
	input  wire logic       ale_i,
	input  wire logic       we_n_i,
	input  wire logic       re_n_i,
	input  wire logic       wp_n_i,
	input  wire logic [7:0] io_i,
	output logic      [7:0] io_o,
	output logic            rb_o,
	output logic            viol_o
);
	logic        en     = 1'b0;
	logic        solid  = 1'b0;
	logic        unp    = 1'b0;
	logic        inv    = 1'b0;
	logic        inv_t  = 1'b0;
	logic [11:0] lo     = 12'h000;
	logic [11:0] up     = 12'h000;
	logic [11:0] lo_t   = 12'h000;
	logic [11:0] blk_t  = 12'h000;
	logic [11:0] qblk   = 12'h000;
	logic [7:0]  cmd    = 8'h00;
	logic [7:0]  sb;
	logic        ins;
	logic        ub;
	logic        drv;
	int          na     = 0;

	initial rb_o = 1'b1;
	initial viol_o = 1'b0;

	// Power-up is the release of reset
	always @(negedge por_i) begin
		en = strap_i;
		solid = 1'b0;
		unp = 1'b0;
	end

	always @(posedge we_n_i) begin
		if (!ce_n_i && cle_i) begin
			cmd = io_i;
			na = 0;
			if (en && io_i == CMD_PROT && !solid)
				unp = 1'b0;
			if (en && io_i == CMD_SOLID && !wp_n_i)
				viol_o = 1'b1;
			if (en && io_i == CMD_SOLID && wp_n_i)
				solid = 1'b1;
			if (io_i == CMD_PROT || io_i == CMD_SOLID) begin
				rb_o = 1'b0;
				rb_o <= #300 1'b1;
			end
		end else if (!ce_n_i && ale_i) begin
			case (na)
				0: begin
					blk_t[1:0] = io_i[7:6];
					inv_t = io_i[0];
				end
				1: blk_t[9:2] = io_i;
				default: blk_t[11:10] = io_i[1:0];
			endcase
			na++;
			if (na == 3 && cmd == CMD_UNP_LO)
				lo_t = blk_t;
			if (na == 3 && cmd == CMD_UNP_UP && en && !solid) begin
				unp = 1'b1;
				lo = lo_t;
				up = blk_t;
				inv = inv_t;
			end
			if (na == 3 && cmd == CMD_BSTAT)
				qblk = blk_t;
		end
	end

	assign ins = (qblk >= lo) && (qblk <= up);
	assign ub = unp && (inv ? !ins : ins);
	// Upper bits are don't care; a pattern shows whether the host masks them
	assign sb = (cmd == CMD_BSTAT) ? {5'b10101, ub, !solid, solid} : 8'hE0;
	assign drv = !ce_n_i && !re_n_i && (en || cmd == CMD_STAT);
	// Released bus shows the inverse so stale data cannot pass
	assign io_o = drv ? sb : ~sb;
endmodule : nbp_flash_model

// ---- sim/tb_nbp_ctrl.sv ----
`timescale 1ns/1ns
module tb_nbp_ctrl
	import nbp_pkg::*;
;
	logic        clk     = 1'b0;
	logic        rst     = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h00000000;
	logic [31:0] prdata;
	logic        pready, pslverr, irq, ce_n, cle, ale, we_n, re_n, wp_n, io_oe, rb, viol;
	logic [7:0]  io_out, io_dev, io_in;
	logic [31:0] rd;
	logic        err;
	logic        en      = 1'b1;
	logic        strap   = 1'b1;
	int          fail_count   = 0;
	int          total_checks = 0;
	logic [11:0] blks [4] = '{12'h102, 12'h103, 12'h2F1, 12'h2F2};
	logic        insd [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

	always #5 clk = ~clk;
	assign io_in = io_oe ? io_out : io_dev;

	nbp_ctrl #(.IO_W(8)) dut (.MCLK_I(clk), .RESET_I(rst), .EN_I(en), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq),
		.CE_N_O(ce_n), .CLE_O(cle), .ALE_O(ale), .WE_N_O(we_n), .RE_N_O(re_n),
		.WP_N_O(wp_n), .IO_I(io_in), .IO_O(io_out), .IO_OE_O(io_oe), .RB_I(rb));

	nbp_flash_model flash (.por_i(rst), .strap_i(strap), .ce_n_i(ce_n), .cle_i(cle),
		.ale_i(ale), .we_n_i(we_n), .re_n_i(re_n), .wp_n_i(wp_n), .io_i(io_in),
		.io_o(io_dev), .rb_o(rb), .viol_o(viol));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic op(input logic [2:0] code);
		int n;
		n = 0;
		apb(OFS_CTRL, 1'b1, {29'h0, code});
		repeat (2) @(posedge clk);
		apb(OFS_STAT, 1'b0, 32'h0);
		while (rd[F_BUSY] !== 1'b0 && n < 300) begin
			apb(OFS_STAT, 1'b0, 32'h0);
			n++;
		end
		chk({31'h0, rd[F_BUSY]}, 32'h0, "operation never finished");
	endtask : op

	task automatic unprot(input logic [11:0] lo, input logic [11:0] up, input logic inv);
		apb(OFS_LOW, 1'b1, {20'h0, lo});
		apb(OFS_UP, 1'b1, {15'h0, inv, 4'h0, up});
		op(3'h1);
	endtask : unprot

	// Status byte keeps the don't-care pattern, so the whole byte is compared
	task automatic bstat(input logic [11:0] blk, input logic u, input logic s);
		apb(OFS_LOW, 1'b1, {20'h0, blk});
		op(3'h4);
		apb(OFS_STAT, 1'b0, 32'h0);
		chk({22'h0, rd[17:8]}, {22'h0, s, u, 5'b10101, u, !s, s}, "block status");
	endtask : bstat

	task automatic end_of_test;
		$display("checks %0d failures %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test

	initial begin
		#200000;
		fail_count++;
		end_of_test();
	end

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({29'h0, wp_n, ce_n, irq}, 32'h2, "pins after reset");
		apb(OFS_IRQ_EN, 1'b0, 32'h0);
		chk(rd, 32'h0, "irq enable reset");
		apb(OFS_STAT, 1'b0, 32'h0);
		chk(rd, 32'h0, "status reset");
		apb(8'h20, 1'b0, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped address");
		apb(OFS_IRQ_EN, 1'b1, 32'h1);
		// Frozen block must ignore a completed bus write
		en <= 1'b0;
		apb(OFS_IRQ_EN, 1'b1, 32'h3);
		en <= 1'b1;
		apb(OFS_IRQ_EN, 1'b0, 32'h0);
		chk(rd, 32'h1, "write ignored while frozen");
		$display("test reset done");
		bstat(12'h005, 1'b0, 1'b0);
		chk({31'h0, irq}, 32'h1, "irq on done");
		apb(OFS_IRQ_CLR, 1'b1, 32'h1);
		apb(OFS_IRQ_ST, 1'b0, 32'h0);
		chk(rd, 32'h0, "irq cleared");
		chk({31'h0, irq}, 32'h0, "irq low");
		op(3'h5);
		apb(OFS_STAT, 1'b0, 32'h0);
		chk({24'h0, rd[15:8]}, 32'hE0, "plain status");
		$display("test default done");
		for (int v = 0; v < 2; v++) begin
			unprot(12'h103, 12'h2F1, v[0]);
			for (int i = 0; i < 4; i++)
				bstat(blks[i], insd[i] ^ v[0], 1'b0);
		end
		$display("test range done");
		op(3'h2);
		bstat(12'h103, 1'b0, 1'b0);
		$display("test protect done");
		unprot(12'h010, 12'h020, 1'b0);
		apb(OFS_CFG, 1'b1, 32'h0);
		op(3'h3);
		chk({31'h0, wp_n}, 32'h1, "write protect raised");
		bstat(12'h010, 1'b1, 1'b1);
		apb(OFS_IRQ_ST, 1'b0, 32'h0);
		chk({31'h0, rd[IRQ_SOLID]}, 32'h1, "lock seen");
		op(3'h2);
		bstat(12'h010, 1'b1, 1'b1);
		unprot(12'h030, 12'h040, 1'b0);
		bstat(12'h030, 1'b0, 1'b1);
		chk({31'h0, viol}, 32'h0, "lock with write protect low");
		$display("test solid done");
		// Power cycle with the strap low: lock must not take, plain status still works
		strap <= 1'b0;
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({29'h0, wp_n, ce_n, irq}, 32'h2, "pins after power cycle");
		op(3'h3);
		chk({31'h0, flash.solid}, 32'h0, "lock taken with strap low");
		op(3'h5);
		apb(OFS_STAT, 1'b0, 32'h0);
		chk({24'h0, rd[15:8]}, 32'hE0, "plain status with strap low");
		$display("test power cycle done");
		end_of_test();
	end
endmodule : tb_nbp_ctrl
